// [core/pwr_pkg.sv]
// package: register map, field positions and carriers for the pwm register bank
package pwr_pkg;
  localparam int          PWR_NUM_INST    = 2;
  localparam int          PWR_AW          = 8;
  // per-instance register bank: base + instance stride
  localparam logic [7:0]  PWR_INST_BASE   = 8'h00;
  localparam logic [7:0]  PWR_INST_STRIDE = 8'h40;
  localparam logic [7:0]  PWR_OFS_OFL     = 8'h00;
  localparam logic [7:0]  PWR_OFS_OFH     = 8'h04;
  localparam logic [7:0]  PWR_OFS_TMRL    = 8'h08;
  localparam logic [7:0]  PWR_OFS_TMRH    = 8'h0C;
  localparam logic [7:0]  PWR_OFS_CTRL    = 8'h10;
  localparam logic [7:0]  PWR_OFS_LDCON   = 8'h14;
  // shared registers
  localparam logic [7:0]  PWR_ADR_ENMIR   = 8'h80;
  localparam logic [7:0]  PWR_ADR_LDMIR   = 8'h84;
  localparam logic [7:0]  PWR_ADR_OUTMIR  = 8'h88;
  localparam logic [7:0]  PWR_ADR_IRQST   = 8'h8C;
  localparam logic [7:0]  PWR_ADR_IRQMSK  = 8'h90;
  // field positions
  localparam int          PWR_CTRL_EN_BIT  = 7;
  localparam int          PWR_CTRL_OUT_BIT = 5;
  localparam int          PWR_LD_ARM_BIT   = 7;
  localparam int          PWR_MIR_LO_BIT   = 4;
  // reset values
  localparam logic [7:0]  PWR_TMR_RST     = 8'h00;
  localparam logic [7:0]  PWR_CTRL_RST    = 8'h00;
  localparam logic [7:0]  PWR_LD_RST      = 8'h00;
  localparam logic [31:0] PWR_ZERO32      = 32'h0000_0000;
  localparam logic [1:0]  PWR_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  PWR_RESP_SLVERR = 2'b10;
  // interrupt status bits: [1:0] load done per inst, [3:2] timer written per inst
  localparam int          PWR_IRQ_W       = 4;

  typedef struct packed {
    logic [15:0] timer;
    logic        enable;
    logic        out_state;
    logic        load_armed;
  } pwr_unit_s;

  typedef struct packed {
    logic [15:0] timer;
    logic        out_state;
    logic        reload_done;
  } pwr_core_s;
endpackage

// [core/pwr_regs.sv]
// file: axi4-lite register bank of the two-instance 16-bit pwm
`timescale 1ns/100ps
module pwr_regs #(
  parameter int NUM_INST = pwr_pkg::PWR_NUM_INST
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic [7:0]                     s_axi_awaddr_i,
  input  wire logic                           s_axi_awvalid_i,
  output logic                                s_axi_awready_o,
  input  wire logic [31:0]                    s_axi_wdata_i,
  input  wire logic [3:0]                     s_axi_wstrb_i,
  input  wire logic                           s_axi_wvalid_i,
  output logic                                s_axi_wready_o,
  output logic [1:0]                          s_axi_bresp_o,
  output logic                                s_axi_bvalid_o,
  input  wire logic                           s_axi_bready_i,
  input  wire logic [7:0]                     s_axi_araddr_i,
  input  wire logic                           s_axi_arvalid_i,
  output logic                                s_axi_arready_o,
  output logic [31:0]                         s_axi_rdata_o,
  output logic [1:0]                          s_axi_rresp_o,
  output logic                                s_axi_rvalid_o,
  input  wire logic                           s_axi_rready_i,
  input  wire pwr_pkg::pwr_core_s [NUM_INST-1:0] core_i,
  output pwr_pkg::pwr_unit_s [NUM_INST-1:0]   unit_o,
  output logic [NUM_INST-1:0][15:0]           offset_count_o,
  output logic [NUM_INST-1:0]                 timer_load_o,
  output logic                                irq_o
);
  import pwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers
  // byte address of one per-instance register
  function automatic logic [7:0] inst_addr(input int i, input logic [7:0] ofs);
    inst_addr = 8'(PWR_INST_BASE + 8'(i) * PWR_INST_STRIDE + ofs);
  endfunction

  function automatic logic inst_hit(input logic [7:0] a, input int i, input logic [7:0] ofs);
    inst_hit = (a == inst_addr(i, ofs));
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    logic k;
    k = (a == PWR_ADR_ENMIR) || (a == PWR_ADR_LDMIR) || (a == PWR_ADR_OUTMIR) ||
        (a == PWR_ADR_IRQST) || (a == PWR_ADR_IRQMSK);
    for (int i = 0; i < NUM_INST; i++) begin
      k = k || inst_hit(a, i, PWR_OFS_OFL) || inst_hit(a, i, PWR_OFS_OFH) ||
          inst_hit(a, i, PWR_OFS_TMRL) || inst_hit(a, i, PWR_OFS_TMRH) ||
          inst_hit(a, i, PWR_OFS_CTRL) || inst_hit(a, i, PWR_OFS_LDCON);
    end
    known_addr = k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_fire;

  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o  = !w_have_q && !bvalid_q;
  assign wr_fire         = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awaddr_q  <= 8'h00;
      aw_have_q <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      awaddr_q  <= s_axi_awaddr_i;
      aw_have_q <= 1'b1;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdata_q  <= PWR_ZERO32;
      wstrb_q  <= 4'h0;
      w_have_q <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      wdata_q  <= s_axi_wdata_i;
      wstrb_q  <= s_axi_wstrb_i;
      w_have_q <= 1'b1;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PWR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= known_addr(awaddr_q) ? PWR_RESP_OKAY : PWR_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 carries data; registers are 8 bits wide
  logic       wr_byte;
  logic [7:0] wbyte;
  assign wr_byte = wr_fire && wstrb_q[0];
  assign wbyte   = wdata_q[7:0];

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_byte && (awaddr_q == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-instance storage
  logic [NUM_INST-1:0][7:0] ofl_q;
  logic [NUM_INST-1:0][7:0] ofh_q;
  logic [NUM_INST-1:0][7:0] tmrh_q;
  logic [NUM_INST-1:0][7:0] tmrl_q;
  logic [NUM_INST-1:0][7:0] ctrl_q;
  logic [NUM_INST-1:0][7:0] ldcon_q;
  logic [NUM_INST-1:0]      timer_load_q;

  ////////////////////////////////////////////////////////////////////////////
  // write strobes, decoded once per register
  logic [NUM_INST-1:0]      wr_ofl;
  logic [NUM_INST-1:0]      wr_ofh;
  logic [NUM_INST-1:0]      wr_tmrl;
  logic [NUM_INST-1:0]      wr_tmrh;
  logic [NUM_INST-1:0]      wr_ctrl;
  logic [NUM_INST-1:0]      wr_ldcon;
  logic                     wr_enmir;
  logic                     wr_ldmir;
  logic                     wr_irqst;
  logic                     wr_irqmsk;

  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      wr_ofl[i]   = wr_at(inst_addr(i, PWR_OFS_OFL));
      wr_ofh[i]   = wr_at(inst_addr(i, PWR_OFS_OFH));
      wr_tmrl[i]  = wr_at(inst_addr(i, PWR_OFS_TMRL));
      wr_tmrh[i]  = wr_at(inst_addr(i, PWR_OFS_TMRH));
      wr_ctrl[i]  = wr_at(inst_addr(i, PWR_OFS_CTRL));
      wr_ldcon[i] = wr_at(inst_addr(i, PWR_OFS_LDCON));
    end
  end

  assign wr_enmir  = wr_at(PWR_ADR_ENMIR);
  assign wr_ldmir  = wr_at(PWR_ADR_LDMIR);
  assign wr_irqst  = wr_at(PWR_ADR_IRQST);
  assign wr_irqmsk = wr_at(PWR_ADR_IRQMSK);

  ////////////////////////////////////////////////////////////////////////////
  // offset count has no reset: contents survive any reset
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (wr_ofl[i]) begin
        ofl_q[i] <= wbyte;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (wr_ofh[i]) begin
        ofh_q[i] <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle load request toward the core after either timer byte is written
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_load_q <= '0;
    end else begin
      timer_load_q <= wr_tmrh | wr_tmrl;
    end
  end

  // written byte stands through the load cycle, then the live count shows again
  // limitation: a later read shows the core count, not the byte written
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmrh_q <= {NUM_INST{PWR_TMR_RST}};
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (wr_tmrh[i]) begin
          tmrh_q[i] <= wbyte;
        end else if (!timer_load_q[i]) begin
          tmrh_q[i] <= core_i[i].timer[15:8];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmrl_q <= {NUM_INST{PWR_TMR_RST}};
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (wr_tmrl[i]) begin
          tmrl_q[i] <= wbyte;
        end else if (!timer_load_q[i]) begin
          tmrl_q[i] <= core_i[i].timer[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control: enable written directly or via the enable mirror
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= '{default: PWR_CTRL_RST};
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (wr_ctrl[i]) begin
          ctrl_q[i] <= wbyte;
        end else if (wr_enmir) begin
          ctrl_q[i][PWR_CTRL_EN_BIT] <= wbyte[PWR_MIR_LO_BIT + i];
        end
        // output state is driven by the waveform core, read-only here
        ctrl_q[i][PWR_CTRL_OUT_BIT] <= core_i[i].out_state;
      end
    end
  end

  // load armed: reload completion wins over a software set in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ldcon_q <= '{default: PWR_LD_RST};
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (wr_ldcon[i]) begin
          ldcon_q[i] <= wbyte;
        end else if (wr_ldmir) begin
          ldcon_q[i][PWR_LD_ARM_BIT] <= wbyte[PWR_MIR_LO_BIT + i];
        end
        if (core_i[i].reload_done) begin
          ldcon_q[i][PWR_LD_ARM_BIT] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mirrors, built from the per-instance bits so they always agree
  logic [7:0] en_mir;
  logic [7:0] ld_mir;
  logic [7:0] out_mir;

  always_comb begin
    en_mir  = 8'h00;
    ld_mir  = 8'h00;
    out_mir = 8'h00;
    for (int i = 0; i < NUM_INST; i++) begin
      en_mir[PWR_MIR_LO_BIT + i]  = ctrl_q[i][PWR_CTRL_EN_BIT];
      ld_mir[PWR_MIR_LO_BIT + i]  = ldcon_q[i][PWR_LD_ARM_BIT];
      out_mir[PWR_MIR_LO_BIT + i] = ctrl_q[i][PWR_CTRL_OUT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: reload done and timer write per instance
  logic [PWR_IRQ_W-1:0] irq_st_q;
  logic [PWR_IRQ_W-1:0] irq_msk_q;
  logic [PWR_IRQ_W-1:0] irq_ev;

  always_comb begin
    irq_ev = '0;
    for (int i = 0; i < NUM_INST; i++) begin
      irq_ev[i]     = core_i[i].reload_done;
      irq_ev[2 + i] = timer_load_q[i];
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_irqst ? wbyte[PWR_IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_msk_q <= '0;
    end else if (wr_irqmsk) begin
      irq_msk_q <= wbyte[PWR_IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_st_q & irq_msk_q);

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_byte;

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  always_comb begin
    rd_byte = 8'h00;
    case (s_axi_araddr_i)
      PWR_ADR_ENMIR:  rd_byte = en_mir;
      PWR_ADR_LDMIR:  rd_byte = ld_mir;
      PWR_ADR_OUTMIR: rd_byte = out_mir;
      PWR_ADR_IRQST:  rd_byte = 8'(irq_st_q);
      PWR_ADR_IRQMSK: rd_byte = 8'(irq_msk_q);
      default: begin
        for (int i = 0; i < NUM_INST; i++) begin
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_OFL))   rd_byte = ofl_q[i];
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_OFH))   rd_byte = ofh_q[i];
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_TMRL))  rd_byte = tmrl_q[i];
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_TMRH))  rd_byte = tmrh_q[i];
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_CTRL))  rd_byte = ctrl_q[i];
          if (inst_hit(s_axi_araddr_i, i, PWR_OFS_LDCON)) rd_byte = ldcon_q[i];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= PWR_ZERO32;
      rresp_q  <= PWR_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= known_addr(s_axi_araddr_i) ? PWR_RESP_OKAY : PWR_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the waveform core
  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      unit_o[i].timer      = {tmrh_q[i], tmrl_q[i]};
      unit_o[i].enable     = ctrl_q[i][PWR_CTRL_EN_BIT];
      unit_o[i].out_state  = ctrl_q[i][PWR_CTRL_OUT_BIT];
      unit_o[i].load_armed = ldcon_q[i][PWR_LD_ARM_BIT];
      offset_count_o[i]    = {ofh_q[i], ofl_q[i]};
    end
  end

  assign timer_load_o = timer_load_q;
endmodule // pwr_regs

// [tb/pwr_regs_monitor.sv]
// checker: bus timing and unit outputs of the pwm register bank
`timescale 1ns/100ps
module pwr_regs_monitor
  import pwr_pkg::*;
#(
  parameter int NUM_INST = PWR_NUM_INST
) (
  input wire logic                     core_clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     s_axi_awvalid_i,
  input wire logic                     s_axi_awready_o,
  input wire logic                     s_axi_wvalid_i,
  input wire logic                     s_axi_wready_o,
  input wire logic                     s_axi_bvalid_o,
  input wire logic                     s_axi_bready_i,
  input wire logic [7:0]               s_axi_araddr_i,
  input wire logic                     s_axi_arvalid_i,
  input wire logic                     s_axi_arready_o,
  input wire logic [31:0]              s_axi_rdata_o,
  input wire logic [1:0]               s_axi_rresp_o,
  input wire logic                     s_axi_rvalid_o,
  input wire logic                     s_axi_rready_i,
  input wire pwr_core_s [NUM_INST-1:0] core_i,
  input wire pwr_unit_s [NUM_INST-1:0] unit_o,
  input wire logic                     irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  wr_late_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
  b_once_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer repeated");
  rd_late_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  r_once_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken while busy");
  bad_adr_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'hFC
    |=> s_axi_rresp_o == PWR_RESP_SLVERR && s_axi_rdata_o == PWR_ZERO32) else $error("unmapped read");
  arm_clear_a: assert property (core_i[0].reload_done |=> !unit_o[0].load_armed)
    else $error("armed bit kept after reload");
  out_follow_a: assert property ($changed(core_i[1].out_state)
    |-> ##[0:2] unit_o[1].out_state == core_i[1].out_state) else $error("output state not copied");
  // reset holds it, so it must not be disabled by reset
  rst_clear_a: assert property (disable iff (1'b0) !arst_n_i
    |-> unit_o[0].timer == 16'h0000 && !unit_o[1].enable && !irq_o) else $error("reset state wrong");
endmodule // pwr_regs_monitor

bind pwr_regs pwr_regs_monitor #(.NUM_INST(NUM_INST)) u_mon (
  .core_clk_i      (core_clk_i),
  .arst_n_i        (arst_n_i),
  .s_axi_awvalid_i (s_axi_awvalid_i),
  .s_axi_awready_o (s_axi_awready_o),
  .s_axi_wvalid_i  (s_axi_wvalid_i),
  .s_axi_wready_o  (s_axi_wready_o),
  .s_axi_bvalid_o  (s_axi_bvalid_o),
  .s_axi_bready_i  (s_axi_bready_i),
  .s_axi_araddr_i  (s_axi_araddr_i),
  .s_axi_arvalid_i (s_axi_arvalid_i),
  .s_axi_arready_o (s_axi_arready_o),
  .s_axi_rdata_o   (s_axi_rdata_o),
  .s_axi_rresp_o   (s_axi_rresp_o),
  .s_axi_rvalid_o  (s_axi_rvalid_o),
  .s_axi_rready_i  (s_axi_rready_i),
  .core_i          (core_i),
  .unit_o          (unit_o),
  .irq_o           (irq_o)
);

// [tb/pwr_regs_bench.sv]
// testbench: directed scenarios for the pwm register bank
`timescale 1ns/100ps
module pwr_regs_bench;
  import pwr_pkg::*;
  localparam logic [7:0] I1 = PWR_INST_STRIDE;
  logic             core_clk_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i;
  // starts high so the first fall reaches the async reset even at time zero
  logic             arst_n_i = 1'b1;
  // answers always accepted at once: the slave never sees a stalled master
  logic             s_axi_bready_i = 1'b1;
  logic             s_axi_rready_i = 1'b1;
  logic [7:0]       s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]      s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0]       s_axi_wstrb_i;
  logic             s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [1:0]       s_axi_bresp_o, s_axi_rresp_o, timer_load_o, r;
  logic [1:0][15:0] offset_count_o;
  pwr_core_s [1:0]  core_i;
  pwr_unit_s [1:0]  unit_o;
  int               failures = 0;
  int               tests_run = 0;
  int               loads0 = 0;
  logic [15:0]      ld_val0;
  pwr_regs u_dut (
    .core_clk_i      (core_clk_i),
    .arst_n_i        (arst_n_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .core_i          (core_i),
    .unit_o          (unit_o),
    .offset_count_o  (offset_count_o),
    .timer_load_o    (timer_load_o),
    .irq_o           (irq_o)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // counts instance 0 load requests and keeps the instance 0 timer word offered with the last one
  always @(posedge core_clk_i) begin
    if (timer_load_o[0] === 1'b1) begin
      loads0  <= loads0 + 1;
      ld_val0 <= unit_o[0].timer;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    failures++;
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, da, dw, b;
    int   n;
    {da, dw, b} = '0;
    n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h000000, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    while (!b) begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid_i && s_axi_awready_o === 1'b1;
      tw = s_axi_wvalid_i && s_axi_wready_o === 1'b1;
      b = da && dw && s_axi_bvalid_o === 1'b1;
      r = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      da |= ta;
      dw |= tw;
      if (++n > 50) timeout();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic t, g;
    int   n;
    {t, g} = '0;
    n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    while (!g) begin
      @(negedge core_clk_i);
      g = t && s_axi_rvalid_o === 1'b1;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      t |= s_axi_arvalid_i && s_axi_arready_o === 1'b1;
      @(posedge core_clk_i);
      if (t) s_axi_arvalid_i <= 1'b0;
      if (++n > 50) timeout();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h000000, e});
  endtask
  task automatic chk_irq(input logic e);
    @(negedge core_clk_i);
    chk(irq_o, e);
    @(posedge core_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mirror;
    rdchk(PWR_ADR_LDMIR, 8'h00);
    rdchk(PWR_ADR_OUTMIR, 8'h00);
    wr(PWR_OFS_CTRL, 8'h80);
    chk(r, PWR_RESP_OKAY);
    rdchk(PWR_ADR_ENMIR, 8'h10);
    wr(PWR_ADR_ENMIR, 8'h20);
    chk(unit_o[1].enable, 1'b1);
    rdchk(I1 + PWR_OFS_CTRL, 8'h80);
    rdchk(PWR_OFS_CTRL, 8'h00);
    wr(PWR_ADR_LDMIR, 8'h30);
    rdchk(PWR_OFS_LDCON, 8'h80);
    core_i[1].out_state <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rdchk(PWR_ADR_OUTMIR, 8'h20);
    rdchk(I1 + PWR_OFS_CTRL, 8'hA0);
    core_i[0].reload_done <= 1'b1;
    @(posedge core_clk_i);
    core_i[0].reload_done <= 1'b0;
    rdchk(PWR_ADR_LDMIR, 8'h20);
    wr(PWR_ADR_LDMIR, 8'h00);
    rdchk(I1 + PWR_OFS_LDCON, 8'h00);
    rdchk(PWR_ADR_IRQST, 8'h01);
    wr(PWR_ADR_IRQMSK, 8'h02);
    chk_irq(1'b0);
    wr(PWR_ADR_IRQMSK, 8'h01);
    chk_irq(1'b1);
    wr(PWR_ADR_IRQST, 8'h01);
    chk_irq(1'b0);
  endtask
  task automatic t_timer;
    int l;
    core_i[0].timer <= 16'hA55A;
    repeat (2) @(posedge core_clk_i);
    rdchk(PWR_OFS_TMRL, 8'h5A);
    rdchk(PWR_OFS_TMRH, 8'hA5);
    l = loads0;
    wr(PWR_OFS_TMRH, 8'h12);
    repeat (4) @(posedge core_clk_i);
    chk(loads0, l + 1);
    chk(ld_val0, 16'h125A);
    wr(PWR_OFS_TMRL, 8'h34);
    repeat (4) @(posedge core_clk_i);
    chk(ld_val0, 16'hA534);
  endtask
  task automatic t_offset;
    wr(I1 + PWR_OFS_OFL, 8'h5A);
    wr(I1 + PWR_OFS_OFH, 8'hC3);
    rdchk(I1 + PWR_OFS_OFH, 8'hC3);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(offset_count_o[1], 16'hC35A);
    chk(unit_o[0].timer, 16'h0000);
    @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rdchk(I1 + PWR_OFS_OFL, 8'h5A);
    rdchk(PWR_ADR_ENMIR, 8'h00);
  endtask
  task automatic t_bus;
    rd(8'hFC);
    chk(r, PWR_RESP_SLVERR);
    chk(d, PWR_ZERO32);
    wr(8'hFC, 8'hFF);
    chk(r, PWR_RESP_SLVERR);
    s_axi_wstrb_i <= 4'h0;
    wr(I1 + PWR_OFS_OFL, 8'h00);
    s_axi_wstrb_i <= 4'h1;
    rdchk(I1 + PWR_OFS_OFL, 8'h5A);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i <= 1'b0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} = '0;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h00000000;
    s_axi_wstrb_i = 4'h1;
    core_i = '0;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_mirror();
    t_timer();
    t_offset();
    t_bus();
    tally_and_finish();
  end
endmodule // pwr_regs_bench
